// *** rtl/mcmot_pkg.sv ***
/*
  Constants, types and the duration table of the mains clocked motion on-timer.
  Assumes a 50 MHz system clock and a mains zero-cross input that toggles
  once per mains half-cycle.
*/
// Notes on behaviour
// - Window comparator leaving its band is the request that starts the on-timer.
// - Requests shorter than five mains half-cycles (50 ms, 41.6 ms) are ignored.
// - After the on-period, retrigger is held off 500 ms (50 Hz) or 600 ms (60 Hz).
// - A second counter, started as the on-timer ends, makes the dead time.
// - On-time is chosen from seven levels given by the duration-select code.
// - Qualification, on and dead timers advance on mains half-cycles only, so durations follow mains.
// - Each triac pulse comes a short fixed delay after a detected zero crossing.
// - The triac gate output is pulsed throughout the on-period.
// - A separate relay output is active for the whole on-period.
// - Daylight from the photoresistor comparator blocks sensor triggers.
// - Leaving reset (power-up) starts the on-timer without any sensor request.
// - Codes map to zero, 4.48 s to 327 s at 50 Hz, or continuous on.
// - On-time is counted in half-cycles, within half a mains cycle.
package mcmot_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and triac firing timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int FIRE_DELAY_NS   = 50000;
  localparam int FIRE_WIDTH_NS   = 20000;
  localparam int FIRE_DELAY_CYC  = (FIRE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIRE_WIDTH_CYC  = (FIRE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIRE_CNT_W      = 13;
  localparam logic [1:0] BOOT_WAIT = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Mains half-cycle based times
  localparam int HALF_US_50HZ       = 10000;
  localparam int HALF_US_60HZ       = 8333;
  localparam int QUAL_TIME_US_50HZ  = 50000;
  localparam int DEAD_TIME_MS_50HZ  = 500;
  localparam int DEAD_TIME_MS_60HZ  = 600;
  localparam int QUAL_CNT_W         = 3;
  localparam int DEAD_CNT_W         = 7;
  localparam int ON_CNT_W           = 16;
  localparam logic [QUAL_CNT_W-1:0] QUAL_HALF =
    QUAL_CNT_W'(QUAL_TIME_US_50HZ / HALF_US_50HZ);
  localparam logic [DEAD_CNT_W-1:0] DEAD_HALF_50 =
    DEAD_CNT_W'(DEAD_TIME_MS_50HZ * 1000 / HALF_US_50HZ);
  localparam logic [DEAD_CNT_W-1:0] DEAD_HALF_60 =
    DEAD_CNT_W'(DEAD_TIME_MS_60HZ * 1000 / HALF_US_60HZ);

  ////////////////////////////////////////////////////////////////////////////
  // On-time levels in milliseconds at 50 Hz and as half-cycle counts
  localparam int ON_TIME_MS_L1 = 4480;
  localparam int ON_TIME_MS_L2 = 40000;
  localparam int ON_TIME_MS_L3 = 81000;
  localparam int ON_TIME_MS_L4 = 163000;
  localparam int ON_TIME_MS_L5 = 327000;
  localparam logic [ON_CNT_W-1:0] ON_HALF_L1 = ON_CNT_W'(ON_TIME_MS_L1 * 1000 / HALF_US_50HZ);
  localparam logic [ON_CNT_W-1:0] ON_HALF_L2 = ON_CNT_W'(ON_TIME_MS_L2 * 1000 / HALF_US_50HZ);
  localparam logic [ON_CNT_W-1:0] ON_HALF_L3 = ON_CNT_W'(ON_TIME_MS_L3 * 1000 / HALF_US_50HZ);
  localparam logic [ON_CNT_W-1:0] ON_HALF_L4 = ON_CNT_W'(ON_TIME_MS_L4 * 1000 / HALF_US_50HZ);
  localparam logic [ON_CNT_W-1:0] ON_HALF_L5 = ON_CNT_W'(ON_TIME_MS_L5 * 1000 / HALF_US_50HZ);

  // Duration codes
  localparam logic [2:0] DSEL_ZERO = 3'h0;
  localparam logic [2:0] DSEL_CONT = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    MCM_IDLE = 2'b00,
    MCM_QUAL = 2'b01,
    MCM_ON   = 2'b11,
    MCM_DEAD = 2'b10
  } mcmot_state_t;

  typedef enum logic [1:0] {
    MCM_FIRE_OFF   = 2'b00,
    MCM_FIRE_WAIT  = 2'b01,
    MCM_FIRE_PULSE = 2'b11
  } mcmot_fire_t;

  typedef struct packed {
    logic       mains_60hz;
    logic       zero_cross;
    logic       motion;
    logic       daylight;
    logic [2:0] dsel;
  } mcmot_pins_t;

  localparam int PINS_W = $bits(mcmot_pins_t);

  // Half-cycle count of a duration code
  function automatic logic [ON_CNT_W-1:0] mcmot_on_len(input logic [2:0] code);
    logic [ON_CNT_W-1:0] len;
    len = '0;
    case (code)
      3'h1:    len = ON_HALF_L1;
      3'h2:    len = ON_HALF_L2;
      3'h3:    len = ON_HALF_L3;
      3'h4:    len = ON_HALF_L4;
      3'h5:    len = ON_HALF_L5;
      default: len = '0;
    endcase
    return len;
  endfunction : mcmot_on_len

endpackage : mcmot_pkg

// *** rtl/mcmot_timer.sv ***
/*
  Digital core of a two-wire motion switch: trigger qualification, on-timer,
  dead time, zero-cross synchronised triac firing and relay drive.
  Assumes all inputs but clk_in, nrst_in and clk_en_in are asynchronous pins and the duration code comes
  already digitised from the analog converter.
*/
`timescale 1ns/10ps
module mcmot_timer #(
  parameter int FIRE_DELAY = mcmot_pkg::FIRE_DELAY_CYC,
  parameter int FIRE_WIDTH = mcmot_pkg::FIRE_WIDTH_CYC
) (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       clk_en_in,
  input  wire logic       mains_zero_cross_in,
  input  wire logic       mains_60hz_in,
  input  wire logic       motion_window_in,
  input  wire logic       daylight_sense_in,
  input  wire logic [2:0] duration_select_in,
  output logic            triac_gate_out,
  output logic            relay_out,
  output logic            on_period_out,
  output logic            holdoff_out
);
  import mcmot_pkg::*;

  localparam logic [FIRE_CNT_W-1:0] FIRE_DELAY_LAST = FIRE_CNT_W'(FIRE_DELAY - 1);
  localparam logic [FIRE_CNT_W-1:0] FIRE_WIDTH_LAST = FIRE_CNT_W'(FIRE_WIDTH - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [PINS_W-1:0] pin_raw;
  logic [PINS_W-1:0] pin_meta;
  logic [PINS_W-1:0] pin_sync;
  mcmot_pins_t       pins;

  assign pin_raw = {mains_60hz_in, mains_zero_cross_in, motion_window_in,
                    daylight_sense_in, duration_select_in};

  genvar gi;
  generate
    for (gi = 0; gi < PINS_W; gi++) begin : g_sync
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else if (clk_en_in) begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  assign pins = mcmot_pins_t'(pin_sync);

  ////////////////////////////////////////////////////////////////////////////
  // Half-cycle tick from zero-cross edges
  logic zc_prev;
  logic next_zc_prev;
  logic half_tick;

  assign half_tick = pins.zero_cross ^ zc_prev;

  always_comb begin
    next_zc_prev = pins.zero_cross;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      zc_prev <= 1'b0;
    end else if (clk_en_in) begin
      zc_prev <= next_zc_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger qualification filter
  logic                  req_ok;
  logic                  trig;
  logic [QUAL_CNT_W-1:0] qual_cnt;
  logic [QUAL_CNT_W-1:0] next_qual_cnt;
  mcmot_state_t          state;
  mcmot_state_t          next_state;

  assign req_ok = pins.motion && !pins.daylight && (state != MCM_DEAD);
  assign trig   = req_ok && half_tick && (qual_cnt == QUAL_HALF - 3'h1);

  always_comb begin
    next_qual_cnt = qual_cnt;
    if (!req_ok) begin
      next_qual_cnt = '0;
    end else if (half_tick && (qual_cnt != QUAL_HALF)) begin
      next_qual_cnt = qual_cnt + 3'h1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      qual_cnt <= '0;
    end else if (clk_en_in) begin
      qual_cnt <= next_qual_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-up start once the synchronisers hold pin values
  logic       boot;
  logic       next_boot;
  logic [1:0] boot_cnt;
  logic [1:0] next_boot_cnt;
  logic       boot_go;

  assign boot_go = boot && (boot_cnt == BOOT_WAIT);

  always_comb begin
    next_boot     = boot;
    next_boot_cnt = boot_cnt;
    if (boot_cnt != BOOT_WAIT) begin
      next_boot_cnt = boot_cnt + 2'h1;
    end
    if (boot_go) begin
      next_boot = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      boot     <= 1'b1;
      boot_cnt <= '0;
    end else if (clk_en_in) begin
      boot     <= next_boot;
      boot_cnt <= next_boot_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // On-timer and dead-time state machine
  logic                  start;
  logic                  cont;
  logic                  next_cont;
  logic [ON_CNT_W-1:0]   on_cnt;
  logic [ON_CNT_W-1:0]   next_on_cnt;
  logic [ON_CNT_W-1:0]   on_len;
  logic [ON_CNT_W-1:0]   next_on_len;
  logic [DEAD_CNT_W-1:0] dead_cnt;
  logic [DEAD_CNT_W-1:0] next_dead_cnt;
  logic [DEAD_CNT_W-1:0] dead_len;

  assign dead_len = pins.mains_60hz ? DEAD_HALF_60 : DEAD_HALF_50;

  always_comb begin
    next_state    = state;
    next_cont     = cont;
    next_on_cnt   = on_cnt;
    next_on_len   = on_len;
    next_dead_cnt = dead_cnt;
    start         = 1'b0;
    case (state)
      MCM_IDLE: begin
        if (boot_go) begin
          start = 1'b1;
        end else if (req_ok && !boot) begin
          next_state = MCM_QUAL;
        end
      end
      MCM_QUAL: begin
        if (!req_ok) begin
          next_state = MCM_IDLE;
        end else if (trig) begin
          start = 1'b1;
        end
      end
      MCM_ON: begin
        if (trig) begin
          start = 1'b1;
        end else if (half_tick && !cont) begin
          if (on_cnt == on_len - 16'h0001) begin
            next_state    = MCM_DEAD;
            next_dead_cnt = '0;
          end else begin
            next_on_cnt = on_cnt + 16'h0001;
          end
        end
      end
      MCM_DEAD: begin
        if (half_tick) begin
          if (dead_cnt == dead_len - 7'h01) begin
            next_state = MCM_IDLE;
          end else begin
            next_dead_cnt = dead_cnt + 7'h01;
          end
        end
      end
      default: begin
        next_state = MCM_IDLE;
      end
    endcase
    if (start) begin
      next_on_cnt = '0;
      next_on_len = mcmot_on_len(pins.dsel);
      next_cont   = (pins.dsel >= DSEL_CONT);
      if (pins.dsel == DSEL_ZERO) begin
        next_state    = MCM_DEAD;
        next_dead_cnt = '0;
      end else begin
        next_state = MCM_ON;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state    <= MCM_IDLE;
      cont     <= 1'b0;
      on_cnt   <= '0;
      on_len   <= '0;
      dead_cnt <= '0;
    end else if (clk_en_in) begin
      state    <= next_state;
      cont     <= next_cont;
      on_cnt   <= next_on_cnt;
      on_len   <= next_on_len;
      dead_cnt <= next_dead_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero-cross synchronised triac firing
  mcmot_fire_t           fire;
  mcmot_fire_t           next_fire;
  logic [FIRE_CNT_W-1:0] fire_cnt;
  logic [FIRE_CNT_W-1:0] next_fire_cnt;

  always_comb begin
    next_fire     = fire;
    next_fire_cnt = fire_cnt;
    case (fire)
      MCM_FIRE_OFF: begin
        if ((state == MCM_ON) && half_tick) begin
          next_fire     = MCM_FIRE_WAIT;
          next_fire_cnt = '0;
        end
      end
      MCM_FIRE_WAIT: begin
        if (fire_cnt == FIRE_DELAY_LAST) begin
          next_fire     = MCM_FIRE_PULSE;
          next_fire_cnt = '0;
        end else begin
          next_fire_cnt = fire_cnt + 13'h0001;
        end
      end
      MCM_FIRE_PULSE: begin
        if (fire_cnt == FIRE_WIDTH_LAST) begin
          next_fire     = MCM_FIRE_OFF;
          next_fire_cnt = '0;
        end else begin
          next_fire_cnt = fire_cnt + 13'h0001;
        end
      end
      default: begin
        next_fire     = MCM_FIRE_OFF;
        next_fire_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fire     <= MCM_FIRE_OFF;
      fire_cnt <= '0;
    end else if (clk_en_in) begin
      fire     <= next_fire;
      fire_cnt <= next_fire_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  logic next_gate;
  logic next_relay;
  logic next_hold;

  always_comb begin
    next_gate  = (next_fire == MCM_FIRE_PULSE);
    next_relay = (next_state == MCM_ON);
    next_hold  = (next_state == MCM_DEAD);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      triac_gate_out <= 1'b0;
      relay_out      <= 1'b0;
      on_period_out  <= 1'b0;
      holdoff_out    <= 1'b0;
    end else if (clk_en_in) begin
      triac_gate_out <= next_gate;
      relay_out      <= next_relay;
      on_period_out  <= next_relay;
      holdoff_out    <= next_hold;
    end
  end

endmodule : mcmot_timer

// *** testbench/mcmot_timer_props.sv ***
/* Port checker of the motion on-timer.
   Assumes clk_en_in held high and stable mode inputs. */
`timescale 1ns/10ps
module mcmot_timer_props #(
  parameter int FIRE_DELAY = 4,
  parameter int FIRE_WIDTH = 2
) (
  input wire logic       clk_in,
  input wire logic       nrst_in,
  input wire logic       clk_en_in,
  input wire logic       mains_zero_cross_in,
  input wire logic       mains_60hz_in,
  input wire logic       motion_window_in,
  input wire logic       daylight_sense_in,
  input wire logic [2:0] duration_select_in,
  input wire logic       triac_gate_out,
  input wire logic       relay_out,
  input wire logic       on_period_out,
  input wire logic       holdoff_out
);
  import mcmot_pkg::*;
  logic [15:0] glen;
  logic [15:0] zage;
  logic [15:0] hot;
  logic        zq;
  logic        up;
  wire  [15:0] dl = mains_60hz_in ? 16'(DEAD_HALF_60) : 16'(DEAD_HALF_50);
  wire         zch = zq != mains_zero_cross_in;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      glen <= '0;
      zage <= '0;
      hot  <= '0;
      zq   <= 1'b0;
      up   <= 1'b0;
    end else begin
      zq   <= mains_zero_cross_in;
      up   <= up | relay_out | holdoff_out;
      zage <= zch ? 16'h0 : zage + 16'h1;
      glen <= triac_gate_out ? glen + 16'h1 : 16'h0;
      hot  <= holdoff_out ? hot + 16'(zch) : 16'h0;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  a_relay_mirror: assert property (@(posedge clk_in) disable iff (!nrst_in)
    relay_out == on_period_out) else $error("relay and on-period differ");
  a_on_dead_excl: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !(relay_out && holdoff_out)) else $error("on and holdoff together");
  a_dead_after_on: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(relay_out) |-> holdoff_out) else $error("no holdoff after on");
  a_dead_length: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(holdoff_out) |-> hot + 16'h2 >= dl && hot <= dl + 16'h2) else $error("holdoff length");
  a_gate_width: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(triac_gate_out) |-> glen == 16'(FIRE_WIDTH)) else $error("gate pulse width");
  a_gate_after_zc: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(triac_gate_out) |-> zage inside {[FIRE_DELAY + 1 : FIRE_DELAY + 6]})
    else $error("gate not after zero cross");
  a_gate_needs_on: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !relay_out && !holdoff_out |-> !triac_gate_out) else $error("gate while idle");
  a_start_by_req: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(relay_out) && up |-> $past(motion_window_in, 4) && !$past(daylight_sense_in, 4))
    else $error("start without request");
  a_start_not_dead: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(relay_out) |-> !$past(holdoff_out)) else $error("start from holdoff");
endmodule : mcmot_timer_props

// *** testbench/mcmot_mains.sv ***
/* Mains source and lamp load facing the timer.
   Assumes HALF clock cycles per mains half-cycle. */
`timescale 1ns/10ps
module mcmot_mains #(
  parameter int HALF = 20
) (
  input  wire logic   clk_in,
  input  wire logic   nrst_in,
  input  wire logic   gate_in,
  output logic        zc_out,
  output logic [31:0] ticks_out,
  output logic [31:0] fires_out
);
  logic [31:0] ph;
  logic        gq;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ph        <= '0;
      gq        <= 1'b0;
      zc_out    <= 1'b0;
      ticks_out <= '0;
      fires_out <= '0;
    end else begin
      gq <= gate_in;
      if (gate_in && !gq) fires_out <= fires_out + 32'h1;
      if (ph == 32'(HALF - 1)) begin
        ph        <= '0;
        zc_out    <= ~zc_out;
        ticks_out <= ticks_out + 32'h1;
      end else begin
        ph <= ph + 32'h1;
      end
    end
  end
endmodule : mcmot_mains

// *** testbench/tb_mcmot_timer.sv ***
/* Self-checking bench of the motion on-timer.
   Assumes the mains model and the port checker beside it. */
`timescale 1ns/10ps
module tb_mcmot_timer;
  import mcmot_pkg::*;
  logic        clk_in, nrst_in, zc, hz60, motion, day, gate, relay, onp, hold;
  logic [2:0]  dsel;
  logic [31:0] ticks, fires;
  int          error_cnt, checks;
  mcmot_timer #(.FIRE_DELAY(4), .FIRE_WIDTH(2)) uut (.clk_in(clk_in), .nrst_in(nrst_in),
    .clk_en_in(1'b1), .mains_zero_cross_in(zc), .mains_60hz_in(hz60),
    .motion_window_in(motion), .daylight_sense_in(day), .duration_select_in(dsel),
    .triac_gate_out(gate), .relay_out(relay), .on_period_out(onp), .holdoff_out(hold));
  mcmot_mains #(.HALF(20)) mains (.clk_in(clk_in), .nrst_in(nrst_in), .gate_in(gate),
    .zc_out(zc), .ticks_out(ticks), .fires_out(fires));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic await(input bit sel, input logic lvl);
    int n;
    n = 0;
    while (((sel ? hold : relay) !== lvl) && n < 20000) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 20000) check(32'h0, 32'h1);
  endtask : await
  task automatic tick_wait(input int n);
    logic [31:0] s;
    s = ticks;
    while (int'(ticks - s) < n) @(negedge clk_in);
  endtask : tick_wait
  task automatic drive(input logic m, input logic [2:0] d);
    @(posedge clk_in);
    motion <= m;
    dsel   <= d;
  endtask : drive
  task automatic span(input logic [31:0] s, input int exp);
    int d;
    await(1, 1'b0);
    d = int'(ticks - s);
    check(32'(d >= exp - 1 && d <= exp + 1), 32'h1);
  endtask : span
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reject();
    drive(1, 3'h1);
    tick_wait(3);
    drive(0, 3'h1);
    tick_wait(1);
    drive(1, 3'h1);
    tick_wait(3);
    drive(0, 3'h1);
    tick_wait(3);
    check(32'(relay), 32'h0);
    @(posedge clk_in);
    day <= 1'b1;
    drive(1, 3'h1);
    tick_wait(8);
    check(32'(relay), 32'h0);
    drive(0, 3'h1);
    day <= 1'b0;
  endtask : t_reject
  task automatic t_dead60();
    logic [31:0] s;
    @(posedge clk_in);
    hz60 <= 1'b1;
    drive(1, 3'h0);
    await(1, 1'b1);
    s = ticks;
    drive(0, 3'h0);
    tick_wait(2);
    drive(1, 3'h1);
    tick_wait(8);
    check(32'(relay), 32'h0);
    drive(0, 3'h1);
    span(s, DEAD_HALF_60);
    @(posedge clk_in);
    hz60 <= 1'b0;
  endtask : t_dead60
  task automatic t_on_code1();
    logic [31:0] s, p;
    int d;
    drive(1, 3'h1);
    await(0, 1'b1);
    s = ticks;
    p = fires;
    drive(0, 3'h1);
    await(0, 1'b0);
    d = int'(ticks - s);
    s = ticks;
    check(32'(d >= ON_HALF_L1 - 1 && d <= ON_HALF_L1 + 1), 32'h1);
    check(32'(hold), 32'h1);
    repeat (12) @(negedge clk_in);
    check(32'(int'(fires - p) >= d - 1 && int'(fires - p) <= d), 32'h1);
    span(s, DEAD_HALF_50);
  endtask : t_on_code1
  task automatic t_cont();
    drive(1, 3'h6);
    await(0, 1'b1);
    drive(0, 3'h6);
    tick_wait(600);
    check(32'(relay), 32'h1);
    drive(1, 3'h7);
    tick_wait(7);
    drive(0, 3'h7);
    tick_wait(300);
    check(32'(onp), 32'h1);
    drive(1, 3'h0);
    tick_wait(7);
    check(32'(relay), 32'h0);
    check(32'(hold), 32'h1);
    drive(0, 3'h0);
    await(1, 1'b0);
  endtask : t_cont
  task automatic t_power();
    logic [31:0] s;
    @(posedge clk_in);
    nrst_in <= 1'b0;
    dsel    <= 3'h1;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(negedge clk_in);
    check(32'(relay), 32'h1);
    check(32'(hold), 32'h0);
    await(0, 1'b0);
    s = ticks;
    check(32'(s >= ON_HALF_L1 - 1 && s <= ON_HALF_L1 + 1), 32'h1);
    span(s, DEAD_HALF_50);
  endtask : t_power
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    nrst_in   = 1'b0;
    hz60      = 1'b0;
    motion    = 1'b0;
    day       = 1'b0;
    dsel      = 3'h0;
    error_cnt = 0;
    checks    = 0;
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(negedge clk_in);
    check(32'(hold), 32'h1);
    span(32'h0, DEAD_HALF_50);
    t_reject();
    t_dead60();
    t_on_code1();
    t_cont();
    t_power();
    summarize();
  end
  initial begin
    #1600000;
    error_cnt++;
    summarize();
  end
endmodule : tb_mcmot_timer
bind mcmot_timer mcmot_timer_props #(.FIRE_DELAY(FIRE_DELAY), .FIRE_WIDTH(FIRE_WIDTH)) props (
  .clk_in(clk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in),
  .mains_zero_cross_in(mains_zero_cross_in), .mains_60hz_in(mains_60hz_in),
  .motion_window_in(motion_window_in), .daylight_sense_in(daylight_sense_in),
  .duration_select_in(duration_select_in), .triac_gate_out(triac_gate_out),
  .relay_out(relay_out), .on_period_out(on_period_out), .holdoff_out(holdoff_out));
